// file: nic_pkg.sv
// Shared constants for the nested interrupt controller.
// Assumes a single 50 MHz clock domain and AXI4-Lite register access.
package nic_pkg;

    // ==========================================================
    // Priority codes (high:low)
    localparam logic [1:0] LVL0_CODE   = 2'h2;
    localparam logic [1:0] LVL1_CODE   = 2'h1;
    localparam logic [1:0] LVL2_CODE   = 2'h0;
    localparam logic [1:0] LVL3_CODE   = 2'h3;
    localparam int         CC_PRIO_HI  = 5;
    localparam int         CC_PRIO_LO  = 3;

    // ==========================================================
    // Vector layout
    localparam int          NUM_VEC      = 16;
    localparam int          NUM_MASK     = 14;
    localparam logic [3:0]  VEC_RESET    = 4'hF;
    localparam logic [3:0]  VEC_TRAP     = 4'hE;
    localparam logic [15:0] VEC_TOP_ADDR = 16'hFFFE;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_PRIO0  = 8'h00;
    localparam logic [7:0] OFS_PRIO1  = 8'h04;
    localparam logic [7:0] OFS_PRIO2  = 8'h08;
    localparam logic [7:0] OFS_PRIO3  = 8'h0C;
    localparam logic [7:0] OFS_CTRL   = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_ENABLE = 8'h18;
    localparam logic [7:0] OFS_HALTC  = 8'h1C;
    localparam logic [7:0] OFS_EDGE   = 8'h20;
    localparam logic [7:0] PRIO_RST   = 8'hFF;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_WAIT  = 2'b01,
        ST_HALT  = 2'b10,
        ST_ENTRY = 2'b11
    } cpu_state_t;

endpackage : nic_pkg

// file: nested_interrupt_controller.sv
// Nested interrupt controller: arbitration, entry/return, wake-up.
// Assumes the core stacks PC, X, A and CC itself when told to.
//
// Operation
// - Sixteen fixed vectors, ordered by hardware priority
// - Current level in CC bits five, three
// - Levels encoded 10,01,00,11; 11 masks all
// - Finish instruction, then stack PC X A CC
// - Entry loads vector priority and vector address
// - Return restores stacked priority bits
// - Highest software level, then hardware order wins
// - Unserviced requests stay latched pending
// - Reset, trap bypass mask; force level 3
// - Reset and trap wake from Halt
// - Trap instruction raises non-maskable entry
// - Reset highest; first code at level 3
// - Maskable needs enable and strictly higher level
// - Edge requests latched, cleared on entry
// - Shared external pins combine by OR
// - Peripheral request needs flag and enable
// - Clear sequence discards pending request
// - Any wakes Wait; halt-capable wake Halt
// - Leaving Halt, serve halt-capable request first
// - Slot zero highest, main program lowest
// - Concurrent no preemption; nested preempts higher
// - Stack overflow not detected
// - Level 0 write to priority field ignored
// - Priority fields reset to all ones
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
module nested_interrupt_controller
    import nic_pkg::*;
#(
    parameter int EXT_PINS = 4
) (
    // Clock, reset, enable
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 clk_en,
    // External pins, OR-grouped per line
    input  wire logic [EXT_PINS-1:0]  ext_pin,
    input  wire logic [NUM_MASK-1:0]  ext_pin_line_sel,
    // Peripheral flags and enables
    input  wire logic [NUM_MASK-1:0]  periph_flag,
    input  wire logic [NUM_MASK-1:0]  periph_en,
    input  wire logic [NUM_MASK-1:0]  periph_clear,
    // Core handshake
    input  wire logic                 insn_boundary,
    input  wire logic                 trap_exec,
    input  wire logic                 irq_ack,
    input  wire logic                 ret_exec,
    input  wire logic [1:0]           ret_prio,
    input  wire logic                 wait_enter,
    input  wire logic                 halt_enter,
    input  wire logic                 nested_mode,
    output logic                      irq_req,
    output logic [3:0]                irq_vec_idx,
    output logic [15:0]               irq_vec_addr,
    output logic                      irq_stack,
    output logic [7:0]                condition_code_register,
    output logic                      cpu_asleep,
    // AXI4-Lite slave
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);

    initial begin
        if (EXT_PINS < 1 || EXT_PINS > 32) begin
            $error("EXT_PINS out of range");
        end
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [31:0]          prio;
        logic [1:0]           cur;
        logic [NUM_MASK-1:0]  edge_pend;
        logic [NUM_MASK-1:0]  line_q;
        logic [NUM_MASK-1:0]  enable;
        logic [NUM_MASK-1:0]  halt_cap;
        logic [NUM_MASK-1:0]  edge_mode;
        logic                 trap_pend;
        logic                 rst_pend;
        logic                 halt_wake;
        cpu_state_t           st;
        logic [3:0]           vec;
        logic [15:0]          vaddr;
        logic                 stack;
        logic                 aw_got;
        logic                 w_got;
        logic [7:0]           awaddr;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // ==========================================================
    // Request sources
    logic [NUM_MASK-1:0] line_lvl;
    logic [NUM_MASK-1:0] pend;
    logic [2:0]          rank [NUM_MASK];

    // Rank: 3 = level 3 ... 0 = level 0
    function automatic logic [2:0] rank_of(input logic [1:0] c);
        case (c)
            LVL0_CODE: rank_of = 3'h0;
            LVL1_CODE: rank_of = 3'h1;
            LVL2_CODE: rank_of = 3'h2;
            default:   rank_of = 3'h3;
        endcase
    endfunction : rank_of

    // Level-0 write protection of a 2-bit field
    function automatic logic [1:0] prio_wr(input logic [1:0] old,
                                           input logic [1:0] nw);
        prio_wr = (nw == LVL0_CODE) ? old : nw;
    endfunction : prio_wr

    genvar g;
    generate
        for (g = 0; g < NUM_MASK; g++) begin : g_src
            logic ext_hit;
            assign ext_hit = ext_pin_line_sel[g] && (|ext_pin);
            assign line_lvl[g] = ext_hit
                || (periph_flag[g] && periph_en[g]);
            assign pend[g] = s_r.edge_mode[g] ? s_r.edge_pend[g]
                                              : line_lvl[g];
            assign rank[g] = rank_of(s_r.prio[2*g +: 2]);
        end
    endgenerate

    // ==========================================================
    // Arbitration
    logic       win_hit;
    logic [3:0] win_idx;
    logic       wake_any;
    logic       wake_halt;
    logic [2:0] cur_rank;

    always_comb begin
        logic [2:0] best;
        logic       elig;
        best      = 3'h0;
        elig      = 1'b0;
        win_hit   = 1'b0;
        win_idx   = 4'h0;
        wake_any  = 1'b0;
        wake_halt = 1'b0;
        cur_rank  = rank_of(s_r.cur);
        // Lower slot index wins ties: scan high to low, >= keeps lowest
        for (int i = NUM_MASK - 1; i >= 0; i--) begin
            elig = pend[i] && s_r.enable[i]
                && (rank[i] > cur_rank)
                && (!s_r.halt_wake || s_r.halt_cap[i]
                    || ext_pin_line_sel[i]);
            if (pend[i] && s_r.enable[i]) begin
                wake_any = 1'b1;
                if (s_r.halt_cap[i] || ext_pin_line_sel[i]) begin
                    wake_halt = 1'b1;
                end
            end
            if (elig && (!win_hit || rank[i] >= best)) begin
                best    = rank[i];
                win_idx = 4'(i);
                win_hit = 1'b1;
            end
        end
    end

    // ==========================================================
    // Next state
    logic       wr_fire;
    logic       rd_fire;
    logic       wr_ok;
    logic [7:0] rd_ofs;
    logic [3:0] vofs;

    always_comb begin
        s_nxt = s_r;
        vofs  = 4'h0;
        // Edge latch of line rising, set wins over clear
        s_nxt.line_q = line_lvl;
        for (int i = 0; i < NUM_MASK; i++) begin
            if (periph_clear[i]) begin
                s_nxt.edge_pend[i] = 1'b0;
            end
            if (irq_ack && s_r.st == ST_ENTRY && s_r.vec == 4'(i)) begin
                s_nxt.edge_pend[i] = 1'b0;
            end
            if (line_lvl[i] && !s_r.line_q[i]) begin
                s_nxt.edge_pend[i] = 1'b1;
            end
        end
        if (trap_exec) begin
            s_nxt.trap_pend = 1'b1;
        end

        case (s_r.st)
            ST_RUN: begin
                if (wait_enter) begin
                    s_nxt.st  = ST_WAIT;
                    s_nxt.cur = LVL0_CODE;
                end else if (halt_enter) begin
                    s_nxt.st  = ST_HALT;
                    s_nxt.cur = LVL0_CODE;
                end else if (ret_exec) begin
                    s_nxt.cur = ret_prio;
                end else if (insn_boundary) begin
                    if (s_r.rst_pend) begin
                        s_nxt.st    = ST_ENTRY;
                        s_nxt.vec   = VEC_RESET;
                        s_nxt.stack = 1'b0;
                    end else if (s_r.trap_pend) begin
                        s_nxt.st    = ST_ENTRY;
                        s_nxt.vec   = VEC_TRAP;
                        s_nxt.stack = 1'b1;
                    end else if (win_hit && (nested_mode
                             || s_r.cur == LVL0_CODE)) begin
                        s_nxt.st    = ST_ENTRY;
                        s_nxt.vec   = win_idx;
                        s_nxt.stack = 1'b1;
                    end
                    // Reset and trap on top, then slot zero downwards
                    vofs = (s_nxt.vec >= VEC_TRAP)
                         ? VEC_RESET - s_nxt.vec
                         : s_nxt.vec - VEC_TRAP;
                    s_nxt.vaddr = VEC_TOP_ADDR
                        - {11'h0, vofs, 1'b0};
                end
            end
            ST_WAIT: begin
                if (wake_any || s_r.trap_pend) begin
                    s_nxt.st = ST_RUN;
                end
            end
            ST_HALT: begin
                if (wake_halt || s_r.trap_pend) begin
                    s_nxt.st        = ST_RUN;
                    s_nxt.halt_wake = 1'b1;
                end
            end
            ST_ENTRY: begin
                if (irq_ack) begin
                    s_nxt.st        = ST_RUN;
                    s_nxt.halt_wake = 1'b0;
                    if (s_r.vec == VEC_RESET) begin
                        s_nxt.rst_pend = 1'b0;
                        s_nxt.cur      = LVL3_CODE;
                    end else if (s_r.vec == VEC_TRAP) begin
                        s_nxt.trap_pend = 1'b0;
                        s_nxt.cur       = LVL3_CODE;
                    end else begin
                        s_nxt.cur = s_r.prio[2*s_r.vec +: 2];
                    end
                end
            end
            default: s_nxt.st = ST_RUN;
        endcase
        // Overflow of nested stacking is not tracked

        // AXI write path
        if (s_axi_awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        wr_ok   = 1'b1;
        if (wr_fire) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            case (s_r.awaddr)
                OFS_PRIO0, OFS_PRIO1, OFS_PRIO2, OFS_PRIO3: begin
                    if (s_r.wstrb[0]) begin
                        for (int k = 0; k < 4; k++) begin
                            s_nxt.prio[8*s_r.awaddr[3:2] + 2*k +: 2] =
                                prio_wr(s_r.prio[8*s_r.awaddr[3:2]
                                        + 2*k +: 2],
                                        s_r.wdata[2*k +: 2]);
                        end
                    end
                end
                OFS_ENABLE: s_nxt.enable    = s_r.wdata[NUM_MASK-1:0];
                OFS_HALTC:  s_nxt.halt_cap  = s_r.wdata[NUM_MASK-1:0];
                OFS_EDGE:   s_nxt.edge_mode = s_r.wdata[NUM_MASK-1:0];
                default:    wr_ok = 1'b0;
            endcase
            s_nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // Upper nibble of the last priority register is read-only ones
        s_nxt.prio[31:28] = 4'hF;

        // AXI read path
        rd_fire = s_axi_arvalid && !s_r.rvalid;
        rd_ofs  = s_axi_araddr;
        if (rd_fire) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = RESP_OKAY;
            case (rd_ofs)
                OFS_PRIO0:  s_nxt.rdata = {24'h0, s_r.prio[7:0]};
                OFS_PRIO1:  s_nxt.rdata = {24'h0, s_r.prio[15:8]};
                OFS_PRIO2:  s_nxt.rdata = {24'h0, s_r.prio[23:16]};
                OFS_PRIO3:  s_nxt.rdata = {24'h0, s_r.prio[31:24]};
                OFS_CTRL:   s_nxt.rdata = {24'h0,
                                           condition_code_register};
                OFS_STATUS: s_nxt.rdata = {16'h0, 2'h0, pend};
                OFS_ENABLE: s_nxt.rdata = {18'h0, s_r.enable};
                OFS_HALTC:  s_nxt.rdata = {18'h0, s_r.halt_cap};
                OFS_EDGE:   s_nxt.rdata = {18'h0, s_r.edge_mode};
                default: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r           <= '0;
            s_r.prio      <= {4{PRIO_RST}};
            s_r.cur       <= LVL3_CODE;
            s_r.rst_pend  <= 1'b1;
            s_r.st        <= ST_RUN;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign irq_req      = s_r.st == ST_ENTRY;
    assign irq_vec_idx  = s_r.vec;
    assign irq_vec_addr = s_r.vaddr;
    assign irq_stack    = s_r.stack;
    assign cpu_asleep   = (s_r.st == ST_WAIT) || (s_r.st == ST_HALT);
    always_comb begin
        condition_code_register             = 8'h0;
        condition_code_register[CC_PRIO_HI] = s_r.cur[1];
        condition_code_register[CC_PRIO_LO] = s_r.cur[0];
    end
    assign s_axi_awready = !s_r.aw_got;
    assign s_axi_wready  = !s_r.w_got;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;

endmodule : nested_interrupt_controller

// file: nic_chk.sv
// Checker for the controller's core-side outputs.
// Bound to the top module; sees only its ports.
module nic_chk
    import nic_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    // Core side
    input wire logic        irq_ack,
    input wire logic        ret_exec,
    input wire logic [1:0]  ret_prio,
    input wire logic        nested_mode,
    input wire logic        irq_req,
    input wire logic [3:0]  irq_vec_idx,
    input wire logic [15:0] irq_vec_addr,
    input wire logic        irq_stack,
    input wire logic [7:0]  condition_code_register
);
    // ==========================================================
    // Properties
    wire logic [1:0] lvl = {condition_code_register[5],
                            condition_code_register[3]};
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    vec_addr_a: assert property (irq_req |->
        irq_vec_addr == ((irq_vec_idx == VEC_RESET) ? 16'hFFFE
            : (irq_vec_idx == VEC_TRAP) ? 16'hFFFC
            : 16'hFFFA - {11'h000, irq_vec_idx, 1'b0}))
        else $error("vector address wrong");
    cc_spare_a: assert property (
        (condition_code_register & 8'hD7) == 8'h00)
        else $error("spare cc bits set");
    reset_nostack_a: assert property (
        irq_req && irq_vec_idx == VEC_RESET |-> !irq_stack)
        else $error("reset entry stacks");
    trap_stack_a: assert property (
        irq_req && irq_vec_idx == VEC_TRAP |-> irq_stack)
        else $error("trap entry not stacked");
    req_hold_a: assert property (
        irq_req && !(irq_ack && clk_en) |=>
        irq_req && $stable(irq_vec_idx))
        else $error("request dropped before ack");
    ack_drop_a: assert property (
        irq_req && irq_ack && clk_en |=> !irq_req)
        else $error("request held after ack");
    nmi_level_a: assert property (
        irq_req && irq_ack && clk_en && irq_vec_idx >= VEC_TRAP |=>
        lvl == LVL3_CODE)
        else $error("level not 3 after nmi entry");
    ret_level_a: assert property (
        ret_exec && clk_en && !irq_req |=> lvl == $past(ret_prio))
        else $error("level not restored on return");
    mask_level_a: assert property (
        $rose(irq_req) && irq_vec_idx < VEC_TRAP && !$past(ret_exec)
        |-> $past(lvl) != LVL3_CODE)
        else $error("maskable taken at level 3");
    concur_main_a: assert property (
        $rose(irq_req) && irq_vec_idx < VEC_TRAP && !nested_mode
        && !$past(ret_exec) |-> $past(lvl) == LVL0_CODE)
        else $error("concurrent entry from handler");

    cover property (irq_req && irq_vec_idx == VEC_TRAP);
    cover property (irq_req && irq_ack && irq_vec_idx < VEC_TRAP);
    cover property (ret_exec && nested_mode);
endmodule : nic_chk

// file: core_model.sv
// Core model: takes entries at instruction boundaries and acks them.
// Assumes the controller holds irq_req until it samples irq_ack.
module core_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Pace and handshake
    input  wire logic       slow,
    input  wire logic       irq_req,
    input  wire logic [3:0] irq_vec_idx,
    output logic            insn_boundary,
    output logic            irq_ack,
    // Entries seen
    output logic [3:0]      ent_idx,
    output int              ent_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] dly_r;
    // ==========================================================
    // Slow mode: two-cycle instructions, late acks
    always @(posedge aclk) begin
        if (!aresetn) begin
            insn_boundary <= 1'b1;
            irq_ack <= 1'b0;
            dly_r <= 2'h0;
            ent_cnt <= 0;
        end else begin
            insn_boundary <= !slow || !insn_boundary;
            if (irq_ack) begin
                irq_ack <= 1'b0;
                dly_r <= 2'h0;
            end else if (irq_req) begin
                if (dly_r == (slow ? 2'h3 : 2'h0)) begin
                    irq_ack <= 1'b1;
                    ent_idx <= irq_vec_idx;
                    ent_cnt <= ent_cnt + 1;
                end else begin
                    dly_r <= dly_r + 2'h1;
                end
            end
        end
    end
endmodule : core_model

// file: test_nested_interrupt_controller.sv
// Self-checking bench for the nested interrupt controller.
// Assumes core_model acks entries; nic_chk is bound below.
module test_nested_interrupt_controller import nic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn, clk_en, trap_exec, ret_exec, wait_enter, halt_enter;
    logic nested_mode, slow, insn_boundary, irq_ack;
    logic [1:0] ret_prio;
    logic [3:0] ext_pin;
    logic [NUM_MASK-1:0] ext_pin_line_sel, periph_flag, periph_en;
    logic [NUM_MASK-1:0] periph_clear;
    logic irq_req, irq_stack, cpu_asleep;
    logic [3:0] irq_vec_idx, ent_idx, i;
    logic [15:0] irq_vec_addr;
    logic [7:0] condition_code_register, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int failures = 0, n_compared = 0, ent_cnt, cyc = 0;

    nested_interrupt_controller DUT (.*);
    core_model u_core (.*);

    always #10 aclk = ~aclk;
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic test_done;
        $display("failures=%0d n_compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        logic ap, wp;
        ap = 1'b1;
        wp = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (ap || wp) begin
            @(posedge aclk);
            if (ap && s_axi_awready) begin
                ap = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (wp && s_axi_wready) begin
                wp = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        b = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] dv,
                      output logic [1:0] rv);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        dv = s_axi_rdata;
        rv = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // Waits for the next entry, checks it, drops its flag
    task automatic enter(input logic [3:0] iv, input logic [1:0] lv);
        int c;
        c = ent_cnt;
        while (ent_cnt == c) @(posedge aclk);
        repeat (3) @(posedge aclk);
        chk("vector", ent_idx, iv);
        chk("level", {condition_code_register[5],
                      condition_code_register[3]}, lv);
        if (iv < VEC_TRAP) periph_flag[iv] <= 1'b0;
    endtask : enter
    task automatic leave(input logic [1:0] lv);
        repeat (2) @(posedge aclk);
        ret_prio <= lv;
        ret_exec <= 1'b1;
        @(posedge aclk) ret_exec <= 1'b0;
    endtask : leave
    task automatic quiet(input int n);
        int c;
        c = ent_cnt;
        repeat (n) @(posedge aclk);
        chk("entries", ent_cnt, c);
    endtask : quiet
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            test_done;
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        {aresetn, trap_exec, ret_exec, wait_enter, halt_enter} = '0;
        {nested_mode, slow, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, ret_prio} = '0;
        {ext_pin, ext_pin_line_sel, periph_flag, periph_clear} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        periph_en = 14'h3FF7;
        clk_en = 1'b1;
        s_axi_wstrb = 4'hF;
        seed = 32'h35;
        repeat (10) @(posedge aclk);
        chk("cc", condition_code_register, 8'h28);
        aresetn <= 1'b1;
        enter(VEC_RESET, LVL3_CODE);
        rd(OFS_PRIO0, d, r);
        chk("prio", d, 32'hFF);
        wr(OFS_PRIO0, 32'hCF);
        wr(OFS_PRIO0, 32'h64);
        rd(OFS_PRIO0, d, r);
        chk("prio", d, 32'h44);
        rd(8'h80, d, r);
        chk("resp", r, RESP_SLVERR);
        wr(8'h84, 32'h0);
        chk("bresp", b, RESP_SLVERR);
        wr(OFS_ENABLE, 32'h3FFF);
        wr(OFS_EDGE, 32'h3FF0);
        ext_pin_line_sel <= 14'h0020;
        ext_pin[0] <= 1'b1;
        @(posedge aclk) ext_pin[0] <= 1'b0;
        @(posedge aclk) periph_clear[5] <= 1'b1;
        @(posedge aclk) periph_clear[5] <= 1'b0;
        leave(LVL0_CODE);
        quiet(20);
        trap_exec <= 1'b1;
        @(posedge aclk) trap_exec <= 1'b0;
        enter(VEC_TRAP, LVL3_CODE);
        periph_flag[0] <= 1'b1;
        quiet(10);
        leave(LVL0_CODE);
        enter(4'h0, LVL2_CODE);
        leave(LVL0_CODE);
        periph_flag <= 14'h000F;
        enter(4'h0, LVL2_CODE);
        leave(LVL0_CODE);
        enter(4'h2, LVL2_CODE);
        leave(LVL0_CODE);
        enter(4'h1, LVL1_CODE);
        leave(LVL0_CODE);
        quiet(20);
        periph_flag[3] <= 1'b0;
        nested_mode <= 1'b1;
        periph_flag[1] <= 1'b1;
        enter(4'h1, LVL1_CODE);
        @(posedge aclk) periph_flag[0] <= 1'b1;
        enter(4'h0, LVL2_CODE);
        leave(LVL1_CODE);
        leave(LVL0_CODE);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            i = 4'(4 + seed[7:0] % 10);
            slow <= seed[8];
            ext_pin_line_sel <= 14'(1) << i;
            ext_pin[seed[10:9]] <= 1'b1;
            @(posedge aclk) ext_pin <= '0;
            enter(i, LVL3_CODE);
            leave(LVL0_CODE);
            quiet(8);
        end
        wait_enter <= 1'b1;
        @(posedge aclk) wait_enter <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("asleep", cpu_asleep, 1'b1);
        clk_en <= 1'b0;
        periph_flag[2] <= 1'b1;
        quiet(6);
        clk_en <= 1'b1;
        enter(4'h2, LVL2_CODE);
        chk("asleep", cpu_asleep, 1'b0);
        leave(LVL0_CODE);
        wr(OFS_HALTC, 32'h4);
        chk("bresp", b, RESP_OKAY);
        halt_enter <= 1'b1;
        @(posedge aclk) halt_enter <= 1'b0;
        periph_flag[0] <= 1'b1;
        quiet(6);
        chk("asleep", cpu_asleep, 1'b1);
        periph_flag[2] <= 1'b1;
        enter(4'h2, LVL2_CODE);
        leave(LVL0_CODE);
        enter(4'h0, LVL2_CODE);
        leave(LVL0_CODE);
        test_done;
    end
endmodule : test_nested_interrupt_controller

bind nested_interrupt_controller nic_chk u_chk (.*);
